// ---- common/ofd_pkg.sv ----
// operand field decoder constants: register numbers, operand kinds,
// address windows and flag update classes.
// assumes a single cpu clock domain; no software-visible registers.
package ofd_pkg;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int BIT_W  = 3;
    localparam int NUM_REGS  = 8;
    localparam int NUM_FLAGS = 3;

    // 8-bit register numbers
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam logic [2:0] REG_D = 3'h5;
    localparam logic [2:0] REG_L = 3'h6;
    localparam logic [2:0] REG_H = 3'h7;

    // register pair numbers
    localparam logic [1:0] PAIR_AX = 2'h0;
    localparam logic [1:0] PAIR_BC = 2'h1;
    localparam logic [1:0] PAIR_DE = 2'h2;
    localparam logic [1:0] PAIR_HL = 2'h3;

    // operand kinds
    localparam logic [2:0] KIND_SADDR    = 3'h0;
    localparam logic [2:0] KIND_SADDRP   = 3'h1;
    localparam logic [2:0] KIND_ABS_BYTE = 3'h2;
    localparam logic [2:0] KIND_ABS_WORD = 3'h3;
    localparam logic [2:0] KIND_CALLT    = 3'h4;
    localparam logic [2:0] KIND_BRANCH   = 3'h5;
    localparam logic [2:0] KIND_IMM      = 3'h6;

    // short direct window
    localparam logic [15:0] SADDR_LO      = 16'hFE20;
    localparam logic [15:0] SADDR_HI      = 16'hFF1F;
    localparam logic [7:0]  SADDR_SPLIT   = 8'h20;
    localparam logic [7:0]  SADDR_PAGE_LO = 8'hFE;
    localparam logic [7:0]  SADDR_PAGE_HI = 8'hFF;

    // call table window
    localparam logic [15:0] CALLT_BASE = 16'h0040;
    localparam logic [15:0] CALLT_TOP  = 16'h007F;
    localparam int          CALLT_W    = 5;

    // flag update classes and flag positions
    localparam logic [2:0] FCLS_KEEP    = 3'h0;
    localparam logic [2:0] FCLS_CLEAR   = 3'h1;
    localparam logic [2:0] FCLS_SET     = 3'h2;
    localparam logic [2:0] FCLS_RESULT  = 3'h3;
    localparam logic [2:0] FCLS_RESTORE = 3'h4;
    localparam int FLAG_Z  = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_CY = 2;

    localparam logic [7:0]  BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [2:0]  FLAGS_RST = 3'h0;
endpackage : ofd_pkg

// ---- core/ofd_decoder.sv ----
// operand field decoder: register file view, operand address checks,
// immediates, branch target and flag update classes.
// assumes all inputs come from cpu logic on the same clock.
`timescale 1ns/1ns
module ofd_decoder (
    input  wire logic        SYS_CLK_I,
    input  wire logic        SRST_I,
    input  wire logic        DEC_VALID_I,
    input  wire logic [2:0]  OPER_KIND_I,
    input  wire logic [2:0]  REG_NUM_I,
    input  wire logic [1:0]  PAIR_NUM_I,
    input  wire logic [7:0]  OPER_LO_I,
    input  wire logic [7:0]  OPER_HI_I,
    input  wire logic [15:0] PC_I,
    input  wire logic        WR_EN_I,
    input  wire logic        WR_WORD_I,
    input  wire logic [15:0] WR_DATA_I,
    input  wire logic        FLAG_UPD_I,
    input  wire logic [8:0]  FLAG_CLASS_I,
    input  wire logic [2:0]  RES_FLAGS_I,
    input  wire logic [2:0]  SAVED_FLAGS_I,
    output logic             DEC_DONE_O,
    output logic [7:0]       REG_BYTE_O,
    output logic [15:0]      PAIR_WORD_O,
    output logic [7:0]       UPPER_BYTE_HALF_O,
    output logic [7:0]       LOWER_BYTE_HALF_O,
    output logic [7:0]       ACC_BYTE_O,
    output logic [15:0]      ACC_WORD_O,
    output logic [15:0]      EFF_ADDR_O,
    output logic             ADDR_OK_O,
    output logic [15:0]      IMM_WORD_O,
    output logic [7:0]       IMM_BYTE_O,
    output logic [2:0]       IMM_BIT_O,
    output logic [2:0]       FLAGS_O
);
    logic [7:0]  regs_q [ofd_pkg::NUM_REGS];
    logic [2:0]  kind_q;
    logic [15:0] ea_d;
    logic        ok_d;
    logic [15:0] saddr_ea;
    logic [15:0] disp_ext;
    logic [15:0] callt_ea;
    logic [2:0]  wr_hi_idx;
    logic [2:0]  wr_lo_idx;
    logic [2:0]  rd_hi_idx;
    logic [2:0]  rd_lo_idx;

    // odd register is the high byte, even register the low byte
    assign wr_hi_idx = {PAIR_NUM_I, 1'b1};
    assign wr_lo_idx = {PAIR_NUM_I, 1'b0};
    assign rd_hi_idx = {PAIR_NUM_I, 1'b1};
    assign rd_lo_idx = {PAIR_NUM_I, 1'b0};

    // register file, one entry per register number; a word write fills both halves
    genvar gi;
    generate
        for (gi = 0; gi < ofd_pkg::NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge SYS_CLK_I) begin
                if (SRST_I) begin
                    regs_q[gi] <= ofd_pkg::BYTE_RST;
                end else if (WR_EN_I && WR_WORD_I && wr_hi_idx == 3'(gi)) begin
                    regs_q[gi] <= WR_DATA_I[15:8];
                end else if (WR_EN_I && WR_WORD_I && wr_lo_idx == 3'(gi)) begin
                    regs_q[gi] <= WR_DATA_I[7:0];
                end else if (WR_EN_I && !WR_WORD_I && REG_NUM_I == 3'(gi)) begin
                    regs_q[gi] <= WR_DATA_I[7:0];
                end
            end
        end
    endgenerate

    // short direct: low byte 20..FF sits in page FE, 00..1F in page FF,
    // so every encoding lands inside the window with no range check needed
    assign saddr_ea = {(OPER_LO_I >= ofd_pkg::SADDR_SPLIT) ? ofd_pkg::SADDR_PAGE_LO
                                                          : ofd_pkg::SADDR_PAGE_HI,
                       OPER_LO_I};
    // call table entries are word spaced from the base
    assign callt_ea = ofd_pkg::CALLT_BASE
                    + {10'h000, OPER_LO_I[ofd_pkg::CALLT_W-1:0], 1'b0};
    // signed displacement widened before the add
    assign disp_ext = {{8{OPER_LO_I[7]}}, OPER_LO_I};

    // effective address and its legality per operand kind
    always_comb begin
        ea_d = {OPER_HI_I, OPER_LO_I};
        ok_d = 1'b1;
        case (OPER_KIND_I)
            ofd_pkg::KIND_SADDR: begin
                ea_d = saddr_ea;
            end
            ofd_pkg::KIND_SADDRP: begin
                ea_d = saddr_ea;
                ok_d = ~OPER_LO_I[0];
            end
            ofd_pkg::KIND_ABS_BYTE: begin
                ea_d = {OPER_HI_I, OPER_LO_I};
            end
            ofd_pkg::KIND_ABS_WORD: begin
                ea_d = {OPER_HI_I, OPER_LO_I};
                ok_d = ~OPER_LO_I[0];
            end
            ofd_pkg::KIND_CALLT: begin
                ea_d = callt_ea;
            end
            ofd_pkg::KIND_BRANCH: begin
                ea_d = PC_I + disp_ext;
            end
            default: begin
                ok_d = 1'b0; // immediates carry no address
            end
        endcase
    end

    // decode results are held until the next request
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            kind_q            <= ofd_pkg::KIND_IMM;
            REG_BYTE_O        <= ofd_pkg::BYTE_RST;
            PAIR_WORD_O       <= ofd_pkg::WORD_RST;
            UPPER_BYTE_HALF_O <= ofd_pkg::BYTE_RST;
            LOWER_BYTE_HALF_O <= ofd_pkg::BYTE_RST;
            EFF_ADDR_O        <= ofd_pkg::WORD_RST;
            ADDR_OK_O         <= 1'b0;
            IMM_WORD_O        <= ofd_pkg::WORD_RST;
            IMM_BYTE_O        <= ofd_pkg::BYTE_RST;
            IMM_BIT_O         <= ofd_pkg::BYTE_RST[ofd_pkg::BIT_W-1:0];
        end else if (DEC_VALID_I) begin
            kind_q            <= OPER_KIND_I;
            REG_BYTE_O        <= regs_q[REG_NUM_I];
            PAIR_WORD_O       <= {regs_q[rd_hi_idx], regs_q[rd_lo_idx]};
            UPPER_BYTE_HALF_O <= regs_q[rd_hi_idx];
            LOWER_BYTE_HALF_O <= regs_q[rd_lo_idx];
            EFF_ADDR_O        <= ea_d;
            ADDR_OK_O         <= ok_d;
            IMM_WORD_O        <= {OPER_HI_I, OPER_LO_I};
            IMM_BYTE_O        <= OPER_LO_I;
            IMM_BIT_O         <= OPER_LO_I[ofd_pkg::BIT_W-1:0];
        end
    end

    // one-cycle completion strobe
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            DEC_DONE_O <= 1'b0;
        end else begin
            DEC_DONE_O <= DEC_VALID_I;
        end
    end

    // accumulators track the register file every cycle, a cycle behind
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            ACC_BYTE_O <= ofd_pkg::BYTE_RST;
            ACC_WORD_O <= ofd_pkg::WORD_RST;
        end else begin
            ACC_BYTE_O <= regs_q[ofd_pkg::REG_A];
            ACC_WORD_O <= {regs_q[ofd_pkg::REG_A], regs_q[ofd_pkg::REG_X]};
        end
    end

    // one update class per flag; undefined class codes keep the flag
    // rather than guess, so a bad decode cannot corrupt the status
    genvar gf;
    generate
        for (gf = 0; gf < ofd_pkg::NUM_FLAGS; gf++) begin : g_flag
            always_ff @(posedge SYS_CLK_I) begin
                if (SRST_I) begin
                    FLAGS_O[gf] <= ofd_pkg::FLAGS_RST[gf];
                end else if (FLAG_UPD_I) begin
                    case (FLAG_CLASS_I[gf*3 +: 3])
                        ofd_pkg::FCLS_CLEAR:   FLAGS_O[gf] <= 1'b0;
                        ofd_pkg::FCLS_SET:     FLAGS_O[gf] <= 1'b1;
                        ofd_pkg::FCLS_RESULT:  FLAGS_O[gf] <= RES_FLAGS_I[gf];
                        ofd_pkg::FCLS_RESTORE: FLAGS_O[gf] <= SAVED_FLAGS_I[gf];
                        default:               FLAGS_O[gf] <= FLAGS_O[gf];
                    endcase
                end
            end
        end
    endgenerate

    // checks on the decoded outputs
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SRST_I);

    property p_reg_acc;
        DEC_VALID_I && REG_NUM_I == ofd_pkg::REG_A |=> REG_BYTE_O == ACC_BYTE_O;
    endproperty
    a_reg_acc: assert property (p_reg_acc) else $error("register 1 is not A");

    property p_pair_src;
        DEC_VALID_I |=> PAIR_WORD_O == $past({regs_q[rd_hi_idx], regs_q[rd_lo_idx]});
    endproperty
    a_pair_src: assert property (p_pair_src) else $error("pair not odd-high");

    property p_pair_halves;
        DEC_DONE_O |-> PAIR_WORD_O == {UPPER_BYTE_HALF_O, LOWER_BYTE_HALF_O};
    endproperty
    a_pair_halves: assert property (p_pair_halves) else $error("halves mismatch");

    property p_pair_ax;
        DEC_VALID_I && PAIR_NUM_I == ofd_pkg::PAIR_AX ##1 !$past(WR_EN_I)
            |-> PAIR_WORD_O == ACC_WORD_O;
    endproperty
    a_pair_ax: assert property (p_pair_ax) else $error("pair 0 is not AX");

    property p_saddr_win;
        DEC_DONE_O && (kind_q == ofd_pkg::KIND_SADDR || kind_q == ofd_pkg::KIND_SADDRP)
            |-> EFF_ADDR_O >= ofd_pkg::SADDR_LO && EFF_ADDR_O <= ofd_pkg::SADDR_HI;
    endproperty
    a_saddr_win: assert property (p_saddr_win) else $error("short direct out of window");

    property p_saddrp_even;
        DEC_DONE_O && kind_q == ofd_pkg::KIND_SADDRP |-> ADDR_OK_O == !EFF_ADDR_O[0];
    endproperty
    a_saddrp_even: assert property (p_saddrp_even) else $error("odd word saddr ok");

    property p_abs_word;
        DEC_VALID_I && OPER_KIND_I == ofd_pkg::KIND_ABS_WORD
            |=> ADDR_OK_O == !$past(OPER_LO_I[0]) && EFF_ADDR_O == $past({OPER_HI_I, OPER_LO_I});
    endproperty
    a_abs_word: assert property (p_abs_word) else $error("abs word check wrong");

    property p_callt;
        DEC_DONE_O && kind_q == ofd_pkg::KIND_CALLT |-> !EFF_ADDR_O[0]
            && EFF_ADDR_O >= ofd_pkg::CALLT_BASE && EFF_ADDR_O <= ofd_pkg::CALLT_TOP;
    endproperty
    a_callt: assert property (p_callt) else $error("call table address wrong");

    property p_imm;
        DEC_VALID_I |=> IMM_WORD_O[7:0] == IMM_BYTE_O && IMM_BIT_O == IMM_BYTE_O[2:0]
            && IMM_WORD_O[15:8] == $past(OPER_HI_I);
    endproperty
    a_imm: assert property (p_imm) else $error("immediate widths wrong");

    property p_acc_word;
        ##1 ACC_WORD_O == $past({regs_q[ofd_pkg::REG_A], regs_q[ofd_pkg::REG_X]});
    endproperty
    a_acc_word: assert property (p_acc_word) else $error("AX not A:X");

    property p_branch;
        DEC_VALID_I && OPER_KIND_I == ofd_pkg::KIND_BRANCH
            |=> EFF_ADDR_O == $past(PC_I) + $past(disp_ext);
    endproperty
    a_branch: assert property (p_branch) else $error("branch target wrong");

    property p_flag_cy;
        FLAG_UPD_I && FLAG_CLASS_I[8:6] == ofd_pkg::FCLS_CLEAR
            |=> !FLAGS_O[ofd_pkg::FLAG_CY] ##1 ($past(FLAG_UPD_I) || $stable(FLAGS_O));
    endproperty
    a_flag_cy: assert property (p_flag_cy) else $error("carry class wrong");

    // write path: the pair checks above only read back, so a misrouted
    // write half would slip past them; check where each write lands
    property p_pair_wr;
        WR_EN_I && WR_WORD_I
            |=> regs_q[{$past(PAIR_NUM_I), 1'b1}] == $past(WR_DATA_I[15:8])
            && regs_q[{$past(PAIR_NUM_I), 1'b0}] == $past(WR_DATA_I[7:0]);
    endproperty
    a_pair_wr: assert property (p_pair_wr) else $error("word write halves misplaced");

    property p_byte_wr;
        WR_EN_I && !WR_WORD_I |=> regs_q[$past(REG_NUM_I)] == $past(WR_DATA_I[7:0]);
    endproperty
    a_byte_wr: assert property (p_byte_wr) else $error("byte write misplaced");

    // the window check alone would pass a stuck low byte; the offset must survive
    property p_saddr_low;
        DEC_VALID_I && OPER_KIND_I == ofd_pkg::KIND_SADDR
            |=> EFF_ADDR_O[7:0] == $past(OPER_LO_I);
    endproperty
    a_saddr_low: assert property (p_saddr_low) else $error("short direct offset lost");

    property p_callt_field;
        DEC_VALID_I && OPER_KIND_I == ofd_pkg::KIND_CALLT
            |=> EFF_ADDR_O[ofd_pkg::CALLT_W:1] == $past(OPER_LO_I[ofd_pkg::CALLT_W-1:0]);
    endproperty
    a_callt_field: assert property (p_callt_field) else $error("call table entry lost");

    // one check per update class other than clear (checked on carry above), spread over the zero and aux carry flags
    property p_flag_set;
        FLAG_UPD_I && FLAG_CLASS_I[2:0] == ofd_pkg::FCLS_SET |=> FLAGS_O[ofd_pkg::FLAG_Z];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("zero flag not set");

    property p_flag_keep;
        FLAG_UPD_I && FLAG_CLASS_I[5:3] == ofd_pkg::FCLS_KEEP
            |=> $stable(FLAGS_O[ofd_pkg::FLAG_AC]);
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("aux carry not kept");

    property p_flag_result;
        FLAG_UPD_I && FLAG_CLASS_I[2:0] == ofd_pkg::FCLS_RESULT
            |=> FLAGS_O[ofd_pkg::FLAG_Z] == $past(RES_FLAGS_I[ofd_pkg::FLAG_Z]);
    endproperty
    a_flag_result: assert property (p_flag_result) else $error("zero flag not from result");

    property p_flag_restore;
        FLAG_UPD_I && FLAG_CLASS_I[5:3] == ofd_pkg::FCLS_RESTORE
            |=> FLAGS_O[ofd_pkg::FLAG_AC] == $past(SAVED_FLAGS_I[ofd_pkg::FLAG_AC]);
    endproperty
    a_flag_restore: assert property (p_flag_restore) else $error("aux carry not restored");

    c_saddr: cover property (DEC_DONE_O && kind_q == ofd_pkg::KIND_SADDR);
    c_back_branch: cover property (DEC_VALID_I && OPER_KIND_I == ofd_pkg::KIND_BRANCH
                                   && OPER_LO_I[7]);
    c_restore: cover property (FLAG_UPD_I && FLAG_CLASS_I[2:0] == ofd_pkg::FCLS_RESTORE);
    c_word_wr: cover property (WR_EN_I && WR_WORD_I ##1 DEC_VALID_I);
endmodule : ofd_decoder

// ---- bench/ofd_fetch_model.sv ----
// fetch stage model: presents one decode request per call of issue.
// assumes the caller runs on the bench clock; released fields show the
// inverse of their last value so a stale operand never reads as valid.
`timescale 1ns/1ns
module ofd_fetch_model (
    input  wire logic        clk_i,
    output logic             valid_o,
    output logic [2:0]       kind_o,
    output logic [2:0]       reg_o,
    output logic [1:0]       pair_o,
    output logic [7:0]       lo_o,
    output logic [7:0]       hi_o,
    output logic [15:0]      pc_o
);
    // idle fields at time zero
    initial begin
        valid_o = 1'b0;
        {kind_o, reg_o, pair_o, lo_o, hi_o, pc_o} = '0;
    end

    // drive after a falling edge, hold over one rising edge, then scramble
    task automatic issue(input logic [2:0] k, input logic [2:0] r, input logic [1:0] p,
                         input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] pc);
        @(negedge clk_i);
        valid_o = 1'b1;
        {kind_o, reg_o, pair_o, lo_o, hi_o, pc_o} = {k, r, p, lo, hi, pc};
        @(negedge clk_i);
        valid_o = 1'b0;
        {kind_o, reg_o, pair_o, lo_o, hi_o, pc_o} = ~{k, r, p, lo, hi, pc};
    endtask : issue
endmodule : ofd_fetch_model

// ---- bench/ofd_testbench.sv ----
// self-checking bench for the operand field decoder.
// assumes the fetch model drives decode fields; writes and flags come from here.
`timescale 1ns/1ns
module testbench;
    logic        clk, srst, wr_en, wr_word, flag_upd;
    logic [2:0]  wr_reg, res_fl, sav_fl;
    logic [1:0]  wr_pair;
    logic [15:0] wr_data;
    logic [8:0]  flag_cls;
    logic        f_valid;
    logic [2:0]  f_kind, f_reg;
    logic [1:0]  f_pair;
    logic [7:0]  f_lo, f_hi;
    logic [15:0] f_pc;
    logic        dec_done, addr_ok;
    logic [7:0]  reg_byte, up_half, low_half, acc_byte, imm_byte;
    logic [15:0] pair_word, acc_word, eff_addr, imm_word;
    logic [2:0]  imm_bit, flags;
    int          failures = 0;
    int          tests_run = 0;

    ofd_fetch_model i_fetch (.clk_i(clk), .valid_o(f_valid), .kind_o(f_kind), .reg_o(f_reg),
        .pair_o(f_pair), .lo_o(f_lo), .hi_o(f_hi), .pc_o(f_pc));

    // register numbers are shared: the write strobe decides who owns them
    ofd_decoder i_dut (.SYS_CLK_I(clk), .SRST_I(srst), .DEC_VALID_I(f_valid),
        .OPER_KIND_I(f_kind), .REG_NUM_I(wr_en ? wr_reg : f_reg),
        .PAIR_NUM_I(wr_en ? wr_pair : f_pair), .OPER_LO_I(f_lo), .OPER_HI_I(f_hi),
        .PC_I(f_pc), .WR_EN_I(wr_en), .WR_WORD_I(wr_word), .WR_DATA_I(wr_data),
        .FLAG_UPD_I(flag_upd), .FLAG_CLASS_I(flag_cls), .RES_FLAGS_I(res_fl),
        .SAVED_FLAGS_I(sav_fl), .DEC_DONE_O(dec_done), .REG_BYTE_O(reg_byte),
        .PAIR_WORD_O(pair_word), .UPPER_BYTE_HALF_O(up_half), .LOWER_BYTE_HALF_O(low_half),
        .ACC_BYTE_O(acc_byte), .ACC_WORD_O(acc_word), .EFF_ADDR_O(eff_addr),
        .ADDR_OK_O(addr_ok), .IMM_WORD_O(imm_word), .IMM_BYTE_O(imm_byte),
        .IMM_BIT_O(imm_bit), .FLAGS_O(flags));

    // clock at 250 MHz
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // decode request; done must stand in the cycle after the taking edge
    task automatic dec(input logic [2:0] k, input logic [2:0] r, input logic [7:0] lo,
                       input logic [7:0] hi, input logic [15:0] pc);
        i_fetch.issue(k, r, r[2:1], lo, hi, pc);
        cmp(16'(dec_done), 16'h0001);
        @(negedge clk);
        cmp(16'(dec_done), 16'h0000);
    endtask : dec

    task automatic wr(input logic w, input logic [2:0] r, input logic [1:0] p,
                      input logic [15:0] d);
        @(negedge clk);
        {wr_en, wr_word, wr_reg, wr_pair, wr_data} = {1'b1, w, r, p, d};
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr

    task automatic fl(input logic [8:0] c, input logic [2:0] e);
        @(negedge clk);
        {flag_upd, flag_cls} = {1'b1, c};
        @(negedge clk);
        flag_upd = 1'b0;
        cmp(16'(flags), 16'(e));
    endtask : fl

    function automatic logic [15:0] pv(input int p);
        return {4'hC, p[3:0], 4'h3, p[3:0]};
    endfunction : pv

    task automatic t_regs();
        logic [15:0] v;
        for (int p = 0; p < 4; p++) wr(1'b1, 3'h0, p[1:0], pv(p));
        for (int n = 0; n < 8; n++) begin
            v = pv(n / 2);
            dec(ofd_pkg::KIND_IMM, n[2:0], 8'h00, 8'h00, 16'h0000);
            cmp(16'(reg_byte), n % 2 ? 16'(v[15:8]) : 16'(v[7:0]));
            cmp(pair_word, v);
            cmp(16'(up_half), 16'(v[15:8]));
            cmp(16'(low_half), 16'(v[7:0]));
        end
        cmp(acc_word, pv(0));
        wr(1'b0, ofd_pkg::REG_A, 2'h0, 16'h005A);
        @(negedge clk);
        cmp(16'(acc_byte), 16'h005A);
        cmp(acc_word, 16'h5A30);
        $display("done t_regs");
    endtask : t_regs

    // window edges, alignment, call table and branch in one sweep
    task automatic t_addr();
        logic [2:0]  k [10] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5};
        logic [15:0] op [10] = '{16'h0020, 16'h001F, 16'h0021, 16'h001E, 16'hFFFF,
                                 16'hFFFF, 16'h0000, 16'h0000, 16'h00FF, 16'h0080};
        logic [15:0] ea [10] = '{16'hFE20, 16'hFF1F, 16'hFE21, 16'hFF1E, 16'hFFFF,
                                 16'hFFFF, 16'h0000, 16'h0040, 16'h007E, 16'h0F80};
        logic        ok [10] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 10; i++) begin
            dec(k[i], 3'h0, op[i][7:0], op[i][15:8], 16'h1000);
            cmp(eff_addr, ea[i]);
            cmp(16'(addr_ok), 16'(ok[i]));
        end
        dec(ofd_pkg::KIND_BRANCH, 3'h0, 8'h7F, 8'h00, 16'h1000);
        cmp(eff_addr, 16'h107F);
        $display("done t_addr");
    endtask : t_addr

    task automatic t_imm();
        dec(ofd_pkg::KIND_IMM, 3'h0, 8'hC3, 8'hA5, 16'h0000);
        cmp(imm_word, 16'hA5C3);
        cmp(16'(imm_byte), 16'h00C3);
        cmp(16'(imm_bit), 16'h0003);
        cmp(16'(addr_ok), 16'h0000);
        $display("done t_imm");
    endtask : t_imm

    // saved flags are {0,1,1}, result flags {1,0,1}
    task automatic t_flags();
        fl({3{ofd_pkg::FCLS_SET}}, 3'b111);
        fl({3{ofd_pkg::FCLS_CLEAR}}, 3'b000);
        fl({3{ofd_pkg::FCLS_SET}}, 3'b111);
        fl({3{ofd_pkg::FCLS_KEEP}}, 3'b111);
        fl({3{ofd_pkg::FCLS_RESULT}}, 3'b101);
        fl({3{ofd_pkg::FCLS_RESTORE}}, 3'b011);
        fl({3{3'h7}}, 3'b011);
        fl({ofd_pkg::FCLS_SET, ofd_pkg::FCLS_CLEAR, ofd_pkg::FCLS_RESTORE}, 3'b101);
        $display("done t_flags");
    endtask : t_flags

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    // reset for ten cycles, then the scenarios in turn
    initial begin
        {srst, wr_en, wr_word, flag_upd} = 4'b1000;
        {wr_reg, wr_pair, wr_data, flag_cls} = '0;
        res_fl = 3'b101;
        sav_fl = 3'b011;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        cmp(16'(flags), 16'h0000);
        t_regs();
        t_addr();
        t_imm();
        t_flags();
        results();
    end
endmodule : testbench
